// ---- pwr_switch_params.svh ----
// register map, reset values, field positions and timing counts of the power switch register bank
`ifndef PWR_SWITCH_PARAMS_SVH
`define PWR_SWITCH_PARAMS_SVH

// register numbers
`define REG_SLOT_A_MAIN_LIMIT_CFG  8'h00
`define REG_SLOT_A_MAIN_TIMING_CFG 8'h01
`define REG_SLOT_A_AUX_CFG         8'h02
`define REG_SLOT_B_MAIN_LIMIT_CFG  8'h03
`define REG_SLOT_B_MAIN_TIMING_CFG 8'h04
`define REG_SLOT_B_AUX_CFG         8'h05
`define REG_SYSTEM_CFG             8'h06
`define REG_LATCHED_EVENT_STATUS   8'h07
`define REG_OVERCURRENT_LATCH      8'h08
`define REG_CHANNEL_LIVE_STATUS    8'h09
`define REG_COUNT                  8'h0a

// reset values
`define RST_MAIN_LIMIT_CFG 8'hbf
`define RST_TIMING_CFG     8'h01
`define RST_SYSTEM_CFG     8'h00

// field positions, limit registers
`define FLD_TRIM_LSB       0
`define FLD_GOOD_LSB       4
`define FLD_ORING_OFFSET   6
`define FLD_ORING_ON       7
// field positions, timing registers
`define FLD_FTIME_LSB      0
`define FLD_CHANNEL_ON     5
`define FLD_START_GATE     6
`define FLD_BLEED          7
// field positions, system register
`define FLD_PULLDOWN_TEST  0
`define FLD_RETRY_SEL      1
`define FLD_AUX_ORING_ON   3
`define FLD_INRUSH_BOOST   4
`define FLD_ALERT_MASK_A   5
`define FLD_ALERT_MASK_B   6
`define FLD_LOSS_OVERRIDE  7

// fault time step and clock period
`define FAULT_UNIT_NS      500000
`define CLK_PERIOD_NS      8
`define FAULT_UNIT_CYC     (`FAULT_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ---- pwr_switch_pkg.sv ----
// types shared by the power switch register bank and its fault timers
package pwr_switch_pkg;

   // channel sequencer states, one-hot
   typedef enum logic [2:0] {
      CH_OFF   = 3'b001,
      CH_RUN   = 3'b010,
      CH_FAULT = 3'b100
   } chan_state_e;

   // fault timer state
   typedef struct packed {
      logic [16:0] pre;
      logic [4:0]  units;
      logic        done;
      logic        pulse;
   } ftimer_s;

   // register bank state
   typedef struct packed {
      logic [6:0][7:0]   cfg;
      logic [7:0]        evt;
      logic [7:0]        ocr;
      logic              alertOe;
      logic [7:0]        rdData;
      chan_state_e [3:0] chState;
      logic [15:0]       syncA;
      logic [15:0]       syncB;
      logic [3:0]        pgPrev;
      logic [3:0]        limPrev;
      logic [3:0]        ftPrev;
      logic              slot_a_pass_gate_drive;
      logic              slot_b_pass_gate_drive;
      logic              blockA;
      logic              blockB;
      logic              auxOnA;
      logic              auxOnB;
   } regs_s;

endpackage

// ---- fault_timer.sv ----
// per-channel fault timer counting half-millisecond units while in current limit
`timescale 1ns/1ps
`default_nettype none

module fault_timer
   import pwr_switch_pkg::*;
#(
   parameter int unsigned UNIT_CYCLES = 62500
) (
   input  wire logic       clk_sys,   // system clock
   input  wire logic       reset_n,   // async reset, active low
   input  wire logic       active,    // channel running and in limit
   input  wire logic [4:0] faultTime, // weighted fault time bits
   output logic            expire     // one-cycle pulse on time-out
);

   ftimer_s st_r;
   ftimer_s st_nxt;

   // count units, stop when elapsed time equals the weighted sum
   always_comb begin
      st_nxt       = st_r;
      st_nxt.pulse = 1'b0;
      if (!active) begin
         st_nxt.pre   = '0;
         st_nxt.units = '0;
         st_nxt.done  = 1'b0;
      end else if (!st_r.done) begin
         if (st_r.units == faultTime) begin
            st_nxt.done  = 1'b1;
            st_nxt.pulse = 1'b1;
         end else if (st_r.pre == 17'(UNIT_CYCLES - 1)) begin
            st_nxt.pre   = '0;
            st_nxt.units = st_r.units + 5'h01;
         end else begin
            st_nxt.pre = st_r.pre + 17'h00001;
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign expire = st_r.pulse;

endmodule // fault_timer

`default_nettype wire

// ---- dual_slot_power_switch_regs.sv ----
// control and status register bank of the dual-slot power switch with channel sequencing
//
// Behaviour
// RQ1 - ten 8-bit registers numbered 0 to 9, selected by register number
// RQ2 - registers 7, 8, 9 read-only, writes ignored; 0 to 6 read and write
// RQ3 - regs 0,1 slot A main; 2 slot A aux; 3,4 slot B main; 5 slot B aux
// RQ4 - register 6 holds eight system configuration bits for both slots
// RQ5 - limit bits 3:0 trim current limit and fast trip, default all ones
// RQ6 - limit bits 5:4 lower power-good threshold when cleared, default ones
// RQ7 - limit bit 6 moves oring turn-off threshold to positive offset
// RQ8 - limit bit 7 cleared forces block gate drive low
// RQ9 - main timing bits 4:0 set fault time in half-ms weights, bit 0 set
// RQ10 - aux bits 4:0 set aux fault time with same weights, bit 0 set
// RQ11 - main timing bit 5 clear drives pass and block gates low
// RQ12 - aux bit 5 clear keeps aux channel disabled
// RQ13 - bit 6 set blocks enabling unless output is below bleed threshold
// RQ14 - bit 7 connects the output bleed resistor when set
// RQ15 - register 7 holds latched fault and good-loss bits; new bits raise alert
// RQ16 - register 8 holds latched over-current and fast-trip events
// RQ17 - register 9 shows live channel status of all four channels
// RQ18 - all registers reached only through the serial management port
// RQ19 - alert is open-drain, pulled low on new status, released on read
// RQ20 - two mask bits keep slot A or slot B status off the alert
// RQ21 - register 7 bits clear on read; fault bit latches on timer expiry
// RQ22 - mode bit selects latch-off or automatic retry after a fault
// RQ23 - fault timer counts in limit, expires at weighted sum, latches fault
`timescale 1ns/1ps
`default_nettype none
`include "pwr_switch_params.svh"

module dual_slot_power_switch_regs
   import pwr_switch_pkg::*;
#(
   parameter int unsigned FAULT_UNIT_CYCLES = `FAULT_UNIT_CYC
) (
   input  wire logic       clk_sys,                  // system clock, 125 MHz
   input  wire logic       reset_n,                  // async reset, active low
   input  wire logic [7:0] regAddr,                  // register number from serial engine
   input  wire logic [7:0] regWrData,                // write data
   input  wire logic       regWrStrobe,              // one-cycle write request
   input  wire logic       regRdStrobe,              // one-cycle read request
   output logic      [7:0] regRdData,                // read data, valid cycle after strobe
   input  wire logic [3:0] inLimitPin,               // channel in current limit
   input  wire logic [3:0] fastTripPin,              // channel fast-trip comparator
   input  wire logic [3:0] powerGoodPin,             // channel output above good threshold
   input  wire logic [3:0] belowBleedPin,            // channel output below bleed threshold
   input  wire logic       statusAlertNIn,           // alert wire level, unused
   output logic            statusAlertNOut,          // alert drive value, always low
   output logic            statusAlertNOe,           // alert pulled low when high
   output logic            slotAPassGateDrive,       // slot A main pass gate on
   output logic            slotABlockGateDrive,      // slot A main block gate on
   output logic            slotBPassGateDrive,       // slot B main pass gate on
   output logic            slotBBlockGateDrive,      // slot B main block gate on
   output logic            slotAAuxOn,               // slot A aux switch on
   output logic            slotBAuxOn,               // slot B aux switch on
   output logic [3:0]      slotAMainLimitTrim,       // slot A limit trim bits
   output logic [1:0]      slotAMainGoodThresh,      // slot A good threshold bits
   output logic            slotAMainOringOffsetSel,  // slot A oring offset select
   output logic [3:0]      slotBMainLimitTrim,       // slot B limit trim bits
   output logic [1:0]      slotBMainGoodThresh,      // slot B good threshold bits
   output logic            slotBMainOringOffsetSel,  // slot B oring offset select
   output logic [3:0]      bleedConnect,             // bleed resistor per channel
   output logic            auxOringOn,               // aux reverse-current blocking on
   output logic            inrushBoost               // main inrush boost select
);

   // channel order: 0 slot A main, 1 slot A aux, 2 slot B main, 3 slot B aux
   localparam logic [3:0][2:0] CTL_IDX = {3'd5, 3'd4, 3'd2, 3'd1};

   regs_s      st_r;
   regs_s      st_nxt;
   logic [3:0] expire;
   logic [3:0] timerActive;

   // one fault timer per channel
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_timer
         assign timerActive[gi] = st_r.syncB[gi] && (st_r.chState[gi] == CH_RUN);  // [RQ23]
         fault_timer #(
            .UNIT_CYCLES (FAULT_UNIT_CYCLES)
         ) u_timer (
            .clk_sys   (clk_sys),
            .reset_n   (reset_n),
            .active    (timerActive[gi]),
            .faultTime (st_r.cfg[CTL_IDX[gi]][4:0]),  // [RQ9] [RQ10]
            .expire    (expire[gi])
         );
      end
   endgenerate

   // next-state of registers, events, alert and channels
   always_comb begin
      logic [3:0] inLim;
      logic [3:0] fTrip;
      logic [3:0] pGood;
      logic [3:0] bBleed;
      logic [7:0] evtSet;
      logic [7:0] ocrSet;
      logic [7:0] live;
      logic [7:0] unmasked;
      logic       retry;
      logic       pdTest;
      logic [7:0] ctl;
      inLim    = st_r.syncB[3:0];
      fTrip    = st_r.syncB[7:4];
      pGood    = st_r.syncB[11:8];
      bBleed   = st_r.syncB[15:12];
      evtSet   = '0;
      ocrSet   = '0;
      live     = '0;
      unmasked = '0;
      ctl      = '0;
      retry    = st_r.cfg[6][`FLD_RETRY_SEL];
      pdTest   = st_r.cfg[6][`FLD_PULLDOWN_TEST];
      st_nxt   = st_r;

      // two-flop synchronisers for analog comparator pins
      st_nxt.syncA = {belowBleedPin, powerGoodPin, fastTripPin, inLimitPin};
      st_nxt.syncB = st_r.syncA;
      st_nxt.pgPrev  = pGood;
      st_nxt.limPrev = inLim;
      st_nxt.ftPrev  = fTrip;

      // event detection per channel
      for (int c = 0; c < 4; c++) begin
         evtSet[2*c]   = st_r.pgPrev[c] && !pGood[c];    // [RQ15]
         evtSet[2*c+1] = expire[c];                      // [RQ21] [RQ23]
         ocrSet[2*c]   = inLim[c] && !st_r.limPrev[c];   // [RQ16]
         ocrSet[2*c+1] = fTrip[c] && !st_r.ftPrev[c];    // [RQ16]
         live[2*c]     = (st_r.chState[c] == CH_RUN);    // [RQ17]
         live[2*c+1]   = pGood[c];                       // [RQ17]
      end

      // register writes, status registers ignore them
      if (regWrStrobe && (regAddr < `REG_LATCHED_EVENT_STATUS)) begin  // [RQ1] [RQ2] [RQ18]
         st_nxt.cfg[regAddr[2:0]] = regWrData;
      end

      // read data mux, unmapped numbers read zero
      if (regRdStrobe) begin
         if (regAddr < `REG_LATCHED_EVENT_STATUS) begin
            st_nxt.rdData = st_r.cfg[regAddr[2:0]];  // [RQ3] [RQ4]
         end else if (regAddr == `REG_LATCHED_EVENT_STATUS) begin
            st_nxt.rdData = st_r.evt;
         end else if (regAddr == `REG_OVERCURRENT_LATCH) begin
            st_nxt.rdData = st_r.ocr;
         end else if (regAddr == `REG_CHANNEL_LIVE_STATUS) begin
            st_nxt.rdData = live;
         end else begin
            st_nxt.rdData = 8'h00;
         end
      end

      // clear on read, a set in the same cycle wins
      st_nxt.evt = st_r.evt | evtSet;
      st_nxt.ocr = st_r.ocr | ocrSet;
      if (regRdStrobe && (regAddr == `REG_LATCHED_EVENT_STATUS)) begin
         st_nxt.evt     = evtSet;  // [RQ21]
         st_nxt.alertOe = 1'b0;    // [RQ19]
      end
      if (regRdStrobe && (regAddr == `REG_OVERCURRENT_LATCH)) begin
         st_nxt.ocr = ocrSet;
      end

      // alert pulled low on any newly set unmasked status bit
      unmasked[3:0] = evtSet[3:0] & {4{!st_r.cfg[6][`FLD_ALERT_MASK_A]}};  // [RQ20]
      unmasked[7:4] = evtSet[7:4] & {4{!st_r.cfg[6][`FLD_ALERT_MASK_B]}};  // [RQ20]
      if (|unmasked) begin
         st_nxt.alertOe = 1'b1;  // [RQ15] [RQ19]
      end

      // channel sequencers
      for (int c = 0; c < 4; c++) begin
         ctl = st_r.cfg[CTL_IDX[c]];
         case (st_r.chState[c])
            CH_OFF: begin
               if (ctl[`FLD_CHANNEL_ON] && (!ctl[`FLD_START_GATE] || bBleed[c])) begin  // [RQ13]
                  st_nxt.chState[c] = CH_RUN;
               end
            end
            CH_RUN: begin
               if (!ctl[`FLD_CHANNEL_ON]) begin  // [RQ11] [RQ12]
                  st_nxt.chState[c] = CH_OFF;
               end else if (expire[c]) begin
                  st_nxt.chState[c] = CH_FAULT;
               end
            end
            CH_FAULT: begin
               if (!ctl[`FLD_CHANNEL_ON] || retry) begin  // [RQ22]
                  st_nxt.chState[c] = CH_OFF;
               end
            end
            default: begin
               st_nxt.chState[c] = CH_OFF;
            end
         endcase
      end

      // gate drives follow the next channel state
      st_nxt.slot_a_pass_gate_drive  = (st_nxt.chState[0] == CH_RUN) && !pdTest;  // [RQ11]
      st_nxt.slot_b_pass_gate_drive  = (st_nxt.chState[2] == CH_RUN) && !pdTest;  // [RQ11]
      st_nxt.blockA = st_nxt.slot_a_pass_gate_drive && st_nxt.cfg[0][`FLD_ORING_ON];  // [RQ8]
      st_nxt.blockB = st_nxt.slot_b_pass_gate_drive && st_nxt.cfg[3][`FLD_ORING_ON];  // [RQ8]
      st_nxt.auxOnA = (st_nxt.chState[1] == CH_RUN);  // [RQ12]
      st_nxt.auxOnB = (st_nxt.chState[3] == CH_RUN);  // [RQ12]
   end

   // state register with documented defaults
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r            <= '0;
         st_r.cfg[0]     <= `RST_MAIN_LIMIT_CFG;  // [RQ5] [RQ6] [RQ7] [RQ8]
         st_r.cfg[1]     <= `RST_TIMING_CFG;
         st_r.cfg[2]     <= `RST_TIMING_CFG;
         st_r.cfg[3]     <= `RST_MAIN_LIMIT_CFG;
         st_r.cfg[4]     <= `RST_TIMING_CFG;
         st_r.cfg[5]     <= `RST_TIMING_CFG;
         st_r.cfg[6]     <= `RST_SYSTEM_CFG;
         st_r.chState[0] <= CH_OFF;
         st_r.chState[1] <= CH_OFF;
         st_r.chState[2] <= CH_OFF;
         st_r.chState[3] <= CH_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state flops, alert drive value tied low
   assign regRdData               = st_r.rdData;
   assign statusAlertNOut         = 1'b0;
   assign statusAlertNOe          = st_r.alertOe;
   assign slotAPassGateDrive      = st_r.slot_a_pass_gate_drive;
   assign slotABlockGateDrive     = st_r.blockA;
   assign slotBPassGateDrive      = st_r.slot_b_pass_gate_drive;
   assign slotBBlockGateDrive     = st_r.blockB;
   assign slotAAuxOn              = st_r.auxOnA;
   assign slotBAuxOn              = st_r.auxOnB;
   assign slotAMainLimitTrim      = st_r.cfg[0][3:0];  // [RQ5]
   assign slotAMainGoodThresh     = st_r.cfg[0][5:4];  // [RQ6]
   assign slotAMainOringOffsetSel = st_r.cfg[0][`FLD_ORING_OFFSET];  // [RQ7]
   assign slotBMainLimitTrim      = st_r.cfg[3][3:0];  // [RQ5]
   assign slotBMainGoodThresh     = st_r.cfg[3][5:4];  // [RQ6]
   assign slotBMainOringOffsetSel = st_r.cfg[3][`FLD_ORING_OFFSET];  // [RQ7]
   assign bleedConnect            = {st_r.cfg[5][`FLD_BLEED], st_r.cfg[4][`FLD_BLEED],
                                     st_r.cfg[2][`FLD_BLEED], st_r.cfg[1][`FLD_BLEED]};  // [RQ14]
   assign auxOringOn              = st_r.cfg[6][`FLD_AUX_ORING_ON];
   assign inrushBoost             = st_r.cfg[6][`FLD_INRUSH_BOOST];

   // checks on register access, alert and channel control
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   chk_rw_write_lands: assert property ( // [RQ1]
      regWrStrobe && (regAddr < 8'h07) |=> st_r.cfg[$past(regAddr[2:0])] == $past(regWrData))
      else $error("config write did not land");

   chk_ro_write_ignored: assert property ( // [RQ2]
      regWrStrobe && (regAddr >= 8'h07) |=> $stable(st_r.cfg))
      else $error("status write changed config");

   chk_sys_read_value: assert property ( // [RQ4]
      regRdStrobe && !regWrStrobe && (regAddr == 8'h06) |=> regRdData == $past(st_r.cfg[6]))
      else $error("system config read wrong");

   chk_alert_release: assert property ( // [RQ19]
      regRdStrobe && (regAddr == 8'h07) && !(|(st_r.pgPrev & ~st_r.syncB[11:8])) && !(|expire)
      |=> !statusAlertNOe)
      else $error("alert not released on status read");

   chk_alert_masked: assert property ( // [RQ20]
      $rose(statusAlertNOe) |-> ((st_r.evt[3:0] != 4'h0) && !st_r.cfg[6][5])
                                || ((st_r.evt[7:4] != 4'h0) && !st_r.cfg[6][6]))
      else $error("alert raised without unmasked status");

   chk_pass_off: assert property ( // [RQ11]
      !st_r.cfg[1][5] |=> !slotAPassGateDrive && !slotABlockGateDrive)
      else $error("disabled main channel still driven");

   chk_block_off: assert property ( // [RQ8]
      !st_r.cfg[0][7] && !(regWrStrobe && (regAddr == 8'h00) && regWrData[7]) |=> !slotABlockGateDrive)
      else $error("block gate on with oring off");

   chk_aux_off: assert property ( // [RQ12]
      !st_r.cfg[2][5] |=> !slotAAuxOn)
      else $error("disabled aux channel still on");

   chk_fault_latch: assert property ( // [RQ21]
      expire[0] |=> st_r.evt[1] ##1 (slotAPassGateDrive == 1'b0))
      else $error("fault not latched or channel not off");

   chk_start_gate: assert property ( // [RQ13]
      (st_r.chState[1] == CH_OFF) && st_r.cfg[2][6] && !st_r.syncB[13] |=> st_r.chState[1] != CH_RUN)
      else $error("start gate ignored");

   chk_latch_off_hold: assert property ( // [RQ22]
      (st_r.chState[0] == CH_FAULT) && !st_r.cfg[6][1] && st_r.cfg[1][5] |=> st_r.chState[0] == CH_FAULT)
      else $error("latched-off channel restarted");

   cov_fault_seen: cover property (expire[0] ##1 st_r.evt[1]);
   cov_alert_cycle: cover property ($rose(statusAlertNOe) ##[1:20] $fell(statusAlertNOe));
   cov_retry: cover property ((st_r.chState[2] == CH_FAULT) ##1 (st_r.chState[2] == CH_OFF));
   cov_oc_event: cover property ($rose(st_r.ocr[0]));

endmodule // dual_slot_power_switch_regs

`default_nettype wire

// ---- mgmt_host_model.sv ----
// management controller model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none

module mgmt_host_model (
   input  wire logic       clk_sys,     // system clock
   output logic      [7:0] regAddr,     // register number
   output logic      [7:0] regWrData,   // write data
   output logic            regWrStrobe, // write request
   output logic            regRdStrobe, // read request
   input  wire logic [7:0] regRdData    // read data
);
   // idle lines at time zero
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrStrobe = 1'h0;
      regRdStrobe = 1'h0;
   end

   // one-cycle write, lines flipped after release so no stale value shows
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      regWrData = d;
      regWrStrobe = 1'h1;
      @(negedge clk_sys);
      regWrStrobe = 1'h0;
      regAddr = ~a;
      regWrData = ~d;
   endtask

   // one-cycle read, data taken once the strobe edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      regRdStrobe = 1'h1;
      @(negedge clk_sys);
      regRdStrobe = 1'h0;
      regAddr = ~a;
      d = regRdData;
   endtask
endmodule // mgmt_host_model

`default_nettype wire

// ---- dual_slot_power_switch_regs_tb.sv ----
// self-checking bench for the power switch register bank
`timescale 1ns/1ps
`default_nettype none

module dual_slot_power_switch_regs_tb;
   typedef struct packed {
      logic       wr;   // write when set, else read and compare
      logic [7:0] addr; // register number
      logic [7:0] data; // write value or expected read value
   } row_s;

   logic       clk_sys, reset_n;
   logic [7:0] regAddr, regWrData, regRdData, rdv;
   logic       regWrStrobe, regRdStrobe;
   logic [3:0] inLimitPin, fastTripPin, powerGoodPin, belowBleedPin;
   logic       statusAlertNOut, statusAlertNOe, slot_a_pass_gate_drive, blockA, auxA;
   logic [3:0] trimA, trimB, bleed;
   logic [1:0] goodA, goodB;
   logic       offA, offB, auxOring, inrush;
   logic       slot_b_pass_gate_drive, blockB, auxB;
   wire logic  statusAlertN;
   int         miscompares, compares;

   // reset values, read-write places, read-only and unmapped places
   row_s rows [0:32] = '{
      '{1'h0, 8'h00, 8'hbf}, '{1'h0, 8'h01, 8'h01}, '{1'h0, 8'h02, 8'h01}, '{1'h0, 8'h03, 8'hbf},
      '{1'h0, 8'h04, 8'h01}, '{1'h0, 8'h05, 8'h01}, '{1'h0, 8'h06, 8'h00}, '{1'h0, 8'h07, 8'h00},
      '{1'h0, 8'h08, 8'h00}, '{1'h0, 8'h09, 8'haa}, '{1'h0, 8'h0a, 8'h00}, '{1'h0, 8'hff, 8'h00},
      '{1'h1, 8'h00, 8'h5a}, '{1'h1, 8'h01, 8'h9e}, '{1'h1, 8'h02, 8'h46}, '{1'h1, 8'h03, 8'ha5},
      '{1'h1, 8'h04, 8'h1f}, '{1'h1, 8'h05, 8'h8c}, '{1'h1, 8'h06, 8'h98}, '{1'h1, 8'h07, 8'hff},
      '{1'h1, 8'h08, 8'hff}, '{1'h1, 8'h09, 8'hff}, '{1'h1, 8'h0c, 8'h77},
      '{1'h0, 8'h00, 8'h5a}, '{1'h0, 8'h01, 8'h9e}, '{1'h0, 8'h02, 8'h46}, '{1'h0, 8'h03, 8'ha5},
      '{1'h0, 8'h04, 8'h1f}, '{1'h0, 8'h05, 8'h8c}, '{1'h0, 8'h06, 8'h98}, '{1'h0, 8'h07, 8'h00},
      '{1'h0, 8'h08, 8'h00}, '{1'h0, 8'h09, 8'haa}};

   // open-drain alert wire with pull-up
   assign statusAlertN = statusAlertNOe ? statusAlertNOut : 1'h1;

   dual_slot_power_switch_regs #(.FAULT_UNIT_CYCLES(4)) uut (
      .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
      .inLimitPin(inLimitPin), .fastTripPin(fastTripPin), .powerGoodPin(powerGoodPin),
      .belowBleedPin(belowBleedPin), .statusAlertNIn(statusAlertN), .statusAlertNOut(statusAlertNOut),
      .statusAlertNOe(statusAlertNOe), .slotAPassGateDrive(slot_a_pass_gate_drive), .slotABlockGateDrive(blockA),
      .slotBPassGateDrive(slot_b_pass_gate_drive), .slotBBlockGateDrive(blockB), .slotAAuxOn(auxA), .slotBAuxOn(auxB),
      .slotAMainLimitTrim(trimA), .slotAMainGoodThresh(goodA), .slotAMainOringOffsetSel(offA),
      .slotBMainLimitTrim(trimB), .slotBMainGoodThresh(goodB), .slotBMainOringOffsetSel(offB),
      .bleedConnect(bleed), .auxOringOn(auxOring), .inrushBoost(inrush));

   mgmt_host_model host (
      .clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData));

   // 125 MHz clock
   initial begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic chk8(input string name, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, rdv);
      chk8(name, rdv, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // cut a hang short
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      print_verdict();
   end

   // main sequence
   initial begin
      reset_n = 1'h0;
      inLimitPin = 4'h0;
      fastTripPin = 4'h0;
      powerGoodPin = 4'hf;
      belowBleedPin = 4'h0;
      miscompares = 0;
      compares = 0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      reset_n = 1'h1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            host.wr(rows[i].addr, rows[i].data);
         end else begin
            rdchk("register", rows[i].addr, rows[i].data);
         end
      end
      chk8("slot A limit fields", {trimA, goodA, offA, 1'h0}, 8'ha6);
      chk8("slot B limit fields", {trimB, goodB, offB, 1'h0}, 8'h58);
      chk8("bleed and system", {bleed, auxOring, inrush, 2'h0}, 8'h9c);
      // reset in mid-run restores defaults
      reset_n = 1'h0;
      cyc(2);
      reset_n = 1'h1;
      rdchk("cfg0 after reset", 8'h00, 8'hbf);
      rdchk("cfg6 after reset", 8'h06, 8'h00);
      // enable slot A main, then drop oring
      host.wr(8'h01, 8'h21);
      cyc(2);
      chk8("gates on", {6'h0, slot_a_pass_gate_drive, blockA}, 8'h03);
      rdchk("live status", 8'h09, 8'hab);
      host.wr(8'h00, 8'h7f);
      cyc(2);
      chk8("block off", {6'h0, slot_a_pass_gate_drive, blockA}, 8'h02);
      host.wr(8'h00, 8'hbf);
      // fault time of three units in current limit
      host.wr(8'h01, 8'h23);
      inLimitPin[0] = 1'h1;
      fastTripPin[0] = 1'h1;
      cyc(12);
      chk8("gates before expiry", {6'h0, slot_a_pass_gate_drive, blockA}, 8'h03);
      cyc(12);
      chk8("fault outputs", {slot_a_pass_gate_drive, blockA, statusAlertNOe, statusAlertN, 4'h0}, 8'h20);
      rdchk("event status", 8'h07, 8'h02);
      chk8("alert released", {7'h0, statusAlertNOe}, 8'h00);
      rdchk("event cleared", 8'h07, 8'h00);
      rdchk("overcurrent", 8'h08, 8'h03);
      inLimitPin[0] = 1'h0;
      fastTripPin[0] = 1'h0;
      cyc(10);
      chk8("latched off", {6'h0, slot_a_pass_gate_drive, blockA}, 8'h00);
      host.wr(8'h06, 8'h02);
      cyc(3);
      chk8("retry restart", {6'h0, slot_a_pass_gate_drive, blockA}, 8'h03);
      host.wr(8'h06, 8'h20);
      // good loss masked on slot A, unmasked on slot B
      powerGoodPin[0] = 1'h0;
      cyc(6);
      chk8("masked alert", {7'h0, statusAlertNOe}, 8'h00);
      rdchk("good loss A", 8'h07, 8'h01);
      powerGoodPin[2] = 1'h0;
      cyc(6);
      chk8("unmasked alert", {7'h0, statusAlertNOe}, 8'h01);
      rdchk("good loss B", 8'h07, 8'h10);
      // aux start gated by bleed threshold
      host.wr(8'h02, 8'h60);
      cyc(6);
      chk8("aux gated", {7'h0, auxA}, 8'h00);
      belowBleedPin[1] = 1'h1;
      cyc(4);
      chk8("aux on", {7'h0, auxA}, 8'h01);
      // slot B main and aux switched on
      host.wr(8'h04, 8'h21);
      host.wr(8'h05, 8'h20);
      cyc(2);
      chk8("slot B gates", {5'h0, slot_b_pass_gate_drive, blockB, auxB}, 8'h07);
      rdchk("live all", 8'h09, 8'hdd);
      print_verdict();
   end
endmodule // dual_slot_power_switch_regs_tb

`default_nettype wire
